// File: logic/dcrs_consts.vh
// Constants for the result-phase status block
`ifndef DCRS_CONSTS_VH
`define DCRS_CONSTS_VH
// Termination codes
`define DCRS_TC_NORMAL   2'h0
`define DCRS_TC_ABNORMAL 2'h1
`define DCRS_TC_INVALID  2'h2
`define DCRS_TC_POLLING  2'h3
// Status byte 0 fields
`define DCRS_S0_TC_HI    7
`define DCRS_S0_TC_LO    6
`define DCRS_S0_POS      5
`define DCRS_S0_HWF      4
`define DCRS_S0_HEAD     2
// Status byte 1 fields
`define DCRS_S1_END      7
`define DCRS_S1_CRC      5
`define DCRS_S1_OVR      4
`define DCRS_S1_NOSEC    2
`define DCRS_S1_WRBLK    1
`define DCRS_S1_IDMA     0
// Status byte 2 fields
`define DCRS_S2_MARK     6
`define DCRS_S2_DCRC     5
`define DCRS_S2_TRK      4
`define DCRS_S2_BAD      1
`define DCRS_S2_DMA      0
// Status byte 3 fields
`define DCRS_S3_WP       6
`define DCRS_S3_ONE5     5
`define DCRS_S3_TRACK_ZERO_IN     4
`define DCRS_S3_ONE3     3
`define DCRS_S3_HEAD     2
// Values
`define DCRS_BAD_TRACK   8'hFF
`define DCRS_LAST_SECTOR 8'hFF
`define DCRS_RECAL_STEPS 7'h50
`define DCRS_DENSITY_SELECT_OUT_RST  1'h1
`endif

// File: logic/dcrs_result_status.v
// Result-phase status bytes of the disk controller
//
// Overview of operation
// - Density select goes high on hardware reset; software resets leave it alone.
// - Result phase hands out the status bytes, one per host read.
// - Byte 0 bits 7:6 hold the termination code.
// - Byte 0 bit 5 set when seek, relative seek or recalibrate completes.
// - Byte 0 bit 4 set on track zero missing after 80 steps or overstep.
// - Byte 0 bit 2 is current head, bits 1:0 current drive.
// - Byte 1 bit 7 set on access past final sector 255.
// - Byte 1 bit 5 set on CRC error in ID or data field.
// - Byte 1 bit 4 set on overrun or underrun.
// - Byte 1 bit 2 set when sector or ID or sequence not found.
// - Byte 1 bit 1 set when write protect rises during a write command.
// - Byte 1 bit 0 set on missing ID mark or missing data mark.
// - Unused status bits read as fixed constants.
// - Byte 2 bit 6 set on data mark type mismatch.
// - Byte 2 bit 5 set on CRC error in data field.
// - Byte 2 bit 4 set on track number mismatch.
// - Byte 2 bit 1 set on track mismatch with ID track FF.
// - Byte 2 bit 0 set when no data mark of either kind found.
// - Byte 3 reports live write protect, track zero, head and drive pins.
`include "dcrs_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module dcrs_result_status #(
    parameter RESULT_BYTES = 4
) (
    // Clock and resets
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_soft_rst,
    // Density select request from the rate logic
    input  wire        i_density_high,
    input  wire        i_density_load,
    // Command sequencing
    input  wire        i_cmd_start,
    input  wire        i_result_start,
    input  wire        i_sense_drive,
    input  wire        i_write_cmd,
    input  wire [1:0]  i_termination_code,
    input  wire        i_termination_load,
    // Execution events: one-cycle pulses, plus the i_recal_active level and the sector and track values
    input  wire        i_positioning_done,
    input  wire        i_recal_step,
    input  wire        i_recal_active,
    input  wire        i_seek_overstep,
    input  wire        i_sector_read,
    input  wire [7:0]  i_sector_number,
    input  wire        i_terminal_count,
    input  wire        i_id_crc_error,
    input  wire        i_data_crc_error,
    input  wire        i_service_late,
    input  wire        i_sector_missing,
    input  wire        i_id_mark_missing,
    input  wire        i_data_mark_missing,
    input  wire        i_mark_mismatch,
    input  wire        i_id_valid,
    input  wire [7:0]  i_id_track,
    input  wire [7:0]  i_current_track,
    // Drive-side state
    input  wire        i_head_select_out,
    input  wire [1:0]  i_drive_select_out,
    input  wire        i_write_protect_pin,
    input  wire        i_track_zero_in,
    // Host data register read
    input  wire        i_data_read,
    // Outputs
    output reg  [7:0]  o_result_data,
    output reg         o_request_for_master,
    output reg         o_transfer_direction,
    output reg         o_result_done,
    output reg         o_density_select_out
);

// ============================================================
// Pin synchronisers
// ============================================================
reg [2:0] wp_sync;
reg [2:0] track_zero_in_sync;
reg       wp_level;
reg       track_zero_in_level;
reg       wp_prev;
always @(posedge i_clock) begin
    if (i_rst) begin
        wp_sync    <= 3'h0;
        track_zero_in_sync  <= 3'h0;
        wp_level   <= 1'h0;
        track_zero_in_level <= 1'h0;
        wp_prev    <= 1'h0;
    end else begin
        wp_sync   <= {wp_sync[1:0], i_write_protect_pin};
        track_zero_in_sync <= {track_zero_in_sync[1:0], i_track_zero_in};
        if (wp_sync[1] == wp_sync[2]) begin
            wp_level <= wp_sync[2];
        end
        if (track_zero_in_sync[1] == track_zero_in_sync[2]) begin
            track_zero_in_level <= track_zero_in_sync[2];
        end
        wp_prev <= wp_level;
    end
end
wire wp_rise = wp_level & ~wp_prev;

// ============================================================
// Density select
// ============================================================
always @(posedge i_clock) begin
    if (i_rst) begin
        o_density_select_out <= `DCRS_DENSITY_SELECT_OUT_RST;
    end else if (i_density_load) begin
        o_density_select_out <= i_density_high;
    end
end

// ============================================================
// Error flags
// ============================================================
reg [1:0] termination_code;
reg       positioning_complete;
reg       hardware_fault_flag;
reg       end_of_track;
reg       crc_fault;
reg       overrun_flag;
reg       sector_not_found;
reg       write_blocked;
reg       id_mark_absent;
reg       mark_type_mismatch;
reg       data_field_crc_fault;
reg       track_mismatch;
reg       bad_track_flag;
reg       data_mark_absent;
reg [6:0] recal_count;
reg       seen_tc;

wire trk_diff   = i_id_valid & (i_id_track != i_current_track);
wire past_last  = i_sector_read & (i_sector_number == `DCRS_LAST_SECTOR) & ~seen_tc;
wire recal_fail = i_recal_active & i_recal_step & ~track_zero_in_level
                  & (recal_count == `DCRS_RECAL_STEPS - 7'h1);
wire clr        = i_cmd_start | i_soft_rst;

always @(posedge i_clock) begin
    if (i_rst) begin
        termination_code     <= `DCRS_TC_NORMAL;
        positioning_complete <= 1'h0;
        hardware_fault_flag  <= 1'h0;
        end_of_track         <= 1'h0;
        crc_fault            <= 1'h0;
        overrun_flag         <= 1'h0;
        sector_not_found     <= 1'h0;
        write_blocked        <= 1'h0;
        id_mark_absent       <= 1'h0;
        mark_type_mismatch   <= 1'h0;
        data_field_crc_fault <= 1'h0;
        track_mismatch       <= 1'h0;
        bad_track_flag       <= 1'h0;
        data_mark_absent     <= 1'h0;
        recal_count          <= 7'h0;
        seen_tc              <= 1'h0;
    end else begin
        // Set wins over the clear in the same cycle
        if (i_termination_load) begin
            termination_code <= i_termination_code;
        end else if (clr) begin
            termination_code <= `DCRS_TC_NORMAL;
        end
        positioning_complete <= i_positioning_done | (positioning_complete & ~clr);
        hardware_fault_flag  <= recal_fail | i_seek_overstep
                                | (hardware_fault_flag & ~clr);
        end_of_track         <= past_last | (end_of_track & ~clr);
        crc_fault            <= i_id_crc_error | i_data_crc_error | (crc_fault & ~clr);
        overrun_flag         <= i_service_late | (overrun_flag & ~clr);
        sector_not_found     <= i_sector_missing | (sector_not_found & ~clr);
        write_blocked        <= (wp_rise & i_write_cmd) | (write_blocked & ~clr);
        id_mark_absent       <= i_id_mark_missing | i_data_mark_missing
                                | (id_mark_absent & ~clr);
        mark_type_mismatch   <= i_mark_mismatch | (mark_type_mismatch & ~clr);
        data_field_crc_fault <= i_data_crc_error | (data_field_crc_fault & ~clr);
        track_mismatch       <= trk_diff | (track_mismatch & ~clr);
        bad_track_flag       <= (trk_diff & (i_id_track == `DCRS_BAD_TRACK))
                                | (bad_track_flag & ~clr);
        data_mark_absent     <= i_data_mark_missing | (data_mark_absent & ~clr);
        // Step counter for the recalibrate check
        if (clr | ~i_recal_active) begin
            recal_count <= 7'h0;
        end else if (i_recal_step && recal_count != `DCRS_RECAL_STEPS) begin
            recal_count <= recal_count + 7'h1;
        end
        seen_tc <= i_terminal_count | (seen_tc & ~clr);
    end
end

// ============================================================
// Status byte assembly
// ============================================================
reg [7:0] status_byte [0:3];
always @* begin
    status_byte[0] = 8'h00;
    status_byte[0][`DCRS_S0_TC_HI:`DCRS_S0_TC_LO] = termination_code;
    status_byte[0][`DCRS_S0_POS]  = positioning_complete;
    status_byte[0][`DCRS_S0_HWF]  = hardware_fault_flag;
    status_byte[0][`DCRS_S0_HEAD] = i_head_select_out;
    status_byte[0][1:0]           = i_drive_select_out;
    status_byte[1] = 8'h00;
    status_byte[1][`DCRS_S1_END]   = end_of_track;
    status_byte[1][`DCRS_S1_CRC]   = crc_fault;
    status_byte[1][`DCRS_S1_OVR]   = overrun_flag;
    status_byte[1][`DCRS_S1_NOSEC] = sector_not_found;
    status_byte[1][`DCRS_S1_WRBLK] = write_blocked;
    status_byte[1][`DCRS_S1_IDMA]  = id_mark_absent;
    status_byte[2] = 8'h00;
    status_byte[2][`DCRS_S2_MARK] = mark_type_mismatch;
    status_byte[2][`DCRS_S2_DCRC] = data_field_crc_fault;
    status_byte[2][`DCRS_S2_TRK]  = track_mismatch;
    status_byte[2][`DCRS_S2_BAD]  = bad_track_flag;
    status_byte[2][`DCRS_S2_DMA]  = data_mark_absent;
    status_byte[3] = 8'h00;
    status_byte[3][`DCRS_S3_ONE5] = 1'h1;
    status_byte[3][`DCRS_S3_ONE3] = 1'h1;
    status_byte[3][`DCRS_S3_WP]   = wp_level;
    status_byte[3][`DCRS_S3_TRACK_ZERO_IN] = track_zero_in_level;
    status_byte[3][`DCRS_S3_HEAD] = i_head_select_out;
    status_byte[3][1:0]           = i_drive_select_out;
end

// ============================================================
// Result phase sequencer
// ============================================================
localparam ST_IDLE   = 1'b0;
localparam ST_RESULT = 1'b1;
reg       state;
reg [2:0] byte_idx;
reg [2:0] last_idx;
always @(posedge i_clock) begin
    if (i_rst | i_soft_rst) begin
        state                <= ST_IDLE;
        byte_idx             <= 3'h0;
        last_idx             <= 3'h0;
        o_result_data        <= 8'h00;
        o_request_for_master <= 1'h0;
        o_transfer_direction <= 1'h0;
        o_result_done        <= 1'h0;
    end else begin
        o_result_done <= 1'h0;
        case (state)
        ST_IDLE: begin
            if (i_result_start) begin
                state    <= ST_RESULT;
                // Drive sense returns only byte 3
                byte_idx <= i_sense_drive ? 3'h3 : 3'h0;
                last_idx <= i_sense_drive ? 3'h3 : RESULT_BYTES[2:0] - 3'h1;
                o_result_data <= i_sense_drive ? status_byte[3] : status_byte[0];
                o_request_for_master <= 1'h1;
                o_transfer_direction <= 1'h1;
            end
        end
        ST_RESULT: begin
            if (i_data_read && o_request_for_master && o_transfer_direction) begin
                if (byte_idx == last_idx) begin
                    state                <= ST_IDLE;
                    o_request_for_master <= 1'h0;
                    o_transfer_direction <= 1'h0;
                    o_result_done        <= 1'h1;
                end else begin
                    byte_idx      <= byte_idx + 3'h1;
                    o_result_data <= status_byte[byte_idx[1:0] + 2'h1];
                end
            end
        end
        default: begin
            state <= ST_IDLE;
        end
        endcase
    end
end
endmodule
`default_nettype wire

// File: test/dcrs_monitor.sv
// Checker for the result-phase status ports
`timescale 1ns/100ps
`default_nettype none
module dcrs_monitor (
    // Clock and resets
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic       i_soft_rst,
    // Inputs watched
    input wire logic       i_density_load,
    input wire logic       i_result_start,
    input wire logic       i_sense_drive,
    input wire logic       i_data_read,
    input wire logic       i_head_select_out,
    input wire logic [1:0] i_drive_select_out,
    // Outputs watched
    input wire logic [7:0] o_result_data,
    input wire logic       o_request_for_master,
    input wire logic       o_transfer_direction,
    input wire logic       o_result_done,
    input wire logic       o_density_select_out
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    wire go = i_result_start && !o_request_for_master && !i_soft_rst;
    wire [2:0] pins = {i_head_select_out, i_drive_select_out};
    property p_dens_hw; $fell(i_rst) |-> o_density_select_out; endproperty
    a_dens_hw: assert property (p_dens_hw) else $error("density low after reset");
    property p_dens_sw;
        i_soft_rst && !i_density_load |=> $stable(o_density_select_out);
    endproperty
    a_dens_sw: assert property (p_dens_sw) else $error("density moved on soft reset");
    property p_idle; $fell(i_rst) |-> !o_request_for_master && !o_result_done; endproperty
    a_idle: assert property (p_idle) else $error("flags set after reset");
    property p_enter; go |=> o_request_for_master && o_transfer_direction; endproperty
    a_enter: assert property (p_enter) else $error("result phase not entered");
    property p_stand;
        o_request_for_master && !i_data_read && !i_soft_rst |=>
            $stable(o_result_data) && o_request_for_master;
    endproperty
    a_stand: assert property (p_stand) else $error("byte changed without read");
    property p_done;
        o_request_for_master && i_data_read && !i_soft_rst ##1 !o_request_for_master
            |-> o_result_done;
    endproperty
    a_done: assert property (p_done) else $error("no done after last byte");
    property p_byte0; go && !i_sense_drive |=> o_result_data[3:0] == {1'b0, $past(pins)};
    endproperty
    a_byte0: assert property (p_byte0) else $error("byte 0 head or drive wrong");
    property p_byte3;
        go && i_sense_drive |=>
            {o_result_data[7], o_result_data[5], o_result_data[3:0]} == {3'b011, $past(pins)};
    endproperty
    a_byte3: assert property (p_byte3) else $error("byte 3 pins wrong");
endmodule
bind dcrs_result_status dcrs_monitor dcrs_monitor_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_soft_rst(i_soft_rst), .i_density_load(i_density_load),
    .i_result_start(i_result_start), .i_sense_drive(i_sense_drive), .i_data_read(i_data_read),
    .i_head_select_out(i_head_select_out), .i_drive_select_out(i_drive_select_out),
    .o_result_data(o_result_data), .o_request_for_master(o_request_for_master),
    .o_transfer_direction(o_transfer_direction), .o_result_done(o_result_done),
    .o_density_select_out(o_density_select_out));
`default_nettype wire

// File: test/dcrs_host_model.sv
// Host reader model for result bytes
`timescale 1ns/100ps
`default_nettype none
module dcrs_host_model (
    // Clock and control
    input  wire logic i_clock,
    input  wire logic i_enable,
    input  wire logic i_slow,
    // Device flags
    input  wire logic i_request_for_master,
    input  wire logic i_transfer_direction,
    // Read strobe
    output var logic  o_data_read
);
    initial o_data_read = 1'b0;
    // Read while offered, slow mode every other cycle
    always @(negedge i_clock) begin
        o_data_read <= i_enable && i_request_for_master && i_transfer_direction
            && !(i_slow && o_data_read);
    end
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Testbench for the result-phase status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_top;
    logic clk = 1'b0, rst = 1'b1, srst = 1'b0, dh = 1'b0, dl = 1'b0, cs = 1'b0, rs = 1'b0;
    logic sense = 1'b0, wcmd = 1'b0, tl = 1'b0, tc = 1'b0, recal = 1'b0, step = 1'b0;
    logic wp = 1'b0, t0 = 1'b0, en = 1'b0, slow = 1'b0, rd, rfm, transfer_direction, done, dens;
    logic [1:0] code = 2'h0;
    logic [2:0] hd_dr = 3'h0;
    logic [7:0] idt = 8'h05, data;
    logic [10:0] ev = 11'h000;
    logic [7:0] got[$];
    int failures = 0, n_compared = 0;
    dcrs_result_status dcrs_result_status_i (
        .i_clock(clk), .i_rst(rst), .i_soft_rst(srst), .i_density_high(dh),
        .i_density_load(dl), .i_cmd_start(cs), .i_result_start(rs), .i_sense_drive(sense),
        .i_write_cmd(wcmd), .i_termination_code(code), .i_termination_load(tl),
        .i_positioning_done(ev[0]), .i_recal_step(step), .i_recal_active(recal),
        .i_seek_overstep(ev[1]), .i_sector_read(ev[9]), .i_sector_number(8'hFF),
        .i_terminal_count(tc), .i_id_crc_error(ev[2]), .i_data_crc_error(ev[3]),
        .i_service_late(ev[4]), .i_sector_missing(ev[5]), .i_id_mark_missing(ev[6]),
        .i_data_mark_missing(ev[7]), .i_mark_mismatch(ev[8]), .i_id_valid(ev[10]),
        .i_id_track(idt), .i_current_track(8'h05), .i_head_select_out(hd_dr[2]),
        .i_drive_select_out(hd_dr[1:0]), .i_write_protect_pin(wp), .i_track_zero_in(t0),
        .i_data_read(rd), .o_result_data(data), .o_request_for_master(rfm),
        .o_transfer_direction(transfer_direction), .o_result_done(done), .o_density_select_out(dens));
    dcrs_host_model dcrs_host_model_i (.i_clock(clk), .i_enable(en), .i_slow(slow),
        .i_request_for_master(rfm), .i_transfer_direction(transfer_direction), .o_data_read(rd));
    always #12.5 clk = ~clk;
    always @(posedge clk) if (rd && rfm && transfer_direction) got.push_back(data);
    task automatic conclude;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic t_res(input logic s, input logic [31:0] x);
        int k;
        got.delete();
        @(negedge clk) {rs, sense, en} = {1'b1, s, 1'b1};
        @(negedge clk) rs = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge clk);
        @(negedge clk) en = 1'b0;
        `CHK(got.size(), s ? 1 : 4)
        for (k = 0; k < got.size(); k++) `CHK(got[k], x[31 - 8 * (s ? 3 : k) -: 8])
    endtask
    task automatic t_cmd(input logic [1:0] c, input logic [2:0] h, input logic [13:0] e,
            input logic [7:0] trk, input logic [23:0] x);
        @(negedge clk) {cs, hd_dr, idt} = {1'b1, h, trk};
        @(negedge clk) {cs, tl, code, tc, wcmd, wp} = {2'b01, c, e[13], e[11], e[11]};
        @(negedge clk) {tl, tc, ev, recal} = {2'b00, e[10:0], e[12]};
        @(negedge clk) ev = 11'h000;
        repeat (e[12] ? 80 : 0) begin
            @(negedge clk) step = 1'b1;
            @(negedge clk) step = 1'b0;
        end
        repeat (8) @(negedge clk);
        {recal, wcmd, wp} = 3'h0;
        repeat (8) @(negedge clk);
        t_res(1'b0, {x, 3'b001, t0, 1'b1, h});
    endtask
    task automatic t_dens;
        `CHK(dens, 1'b1)
        @(negedge clk) {dh, dl} = 2'b01;
        @(negedge clk) {dl, srst} = 2'b01;
        @(negedge clk) srst = 1'b0;
        @(negedge clk) `CHK(dens, 1'b0)
        rst = 1'b1;
        @(negedge clk) rst = 1'b0;
        `CHK(dens, 1'b1)
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_dens();
        for (int c = 0; c < 4; c++)
            t_cmd(2'(c), 3'(5 - c), 14'h0, 8'h05, {2'(c), 3'h0, 3'(5 - c), 16'h0});
        {t0, wp, hd_dr, slow} = 6'b111101;
        repeat (8) @(negedge clk);
        t_res(1'b1, 32'h7E);
        t0 = 1'b0;
        t_cmd(2'h0, 3'h0, 14'h0001, 8'h05, 24'h200000);
        t_cmd(2'h0, 3'h0, 14'h0002, 8'h05, 24'h100000);
        t_cmd(2'h0, 3'h0, 14'h1000, 8'h05, 24'h100000);
        t_cmd(2'h0, 3'h0, 14'h0004, 8'h05, 24'h002000);
        t_cmd(2'h0, 3'h0, 14'h0008, 8'h05, 24'h002020);
        t_cmd(2'h0, 3'h0, 14'h0010, 8'h05, 24'h001000);
        t_cmd(2'h0, 3'h0, 14'h0020, 8'h05, 24'h000400);
        t_cmd(2'h0, 3'h0, 14'h0040, 8'h05, 24'h000100);
        t_cmd(2'h0, 3'h0, 14'h0080, 8'h05, 24'h000101);
        t_cmd(2'h0, 3'h0, 14'h0100, 8'h05, 24'h000040);
        t_cmd(2'h0, 3'h0, 14'h0200, 8'h05, 24'h008000);
        t_cmd(2'h0, 3'h0, 14'h2200, 8'h05, 24'h000000);
        t_cmd(2'h0, 3'h0, 14'h0400, 8'h03, 24'h000010);
        t_cmd(2'h0, 3'h0, 14'h0400, 8'hFF, 24'h000012);
        t_cmd(2'h0, 3'h0, 14'h0800, 8'h05, 24'h000200);
        conclude();
    end
    initial begin
        #(25 * 20000);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
